// file: core/mbcc_seq.v
// Purpose: memory bus cycle sequencer with ready driven wait states
// Assumes: clk_sys steps one clock phase per edge; four edges make one clock cycle
// Notes: a request is taken only at the end of phase four of an idle clock cycle
// Notes: ready and read data pass two flops, so the pin value that decides a
//   cycle is the one that stood two phases before the decision edge
// Notes: wait fed straight back therefore costs one more wait state than on a
//   part that samples ready without synchronising it; the cycle still grows
//   by whole clock periods only
// Notes: one request at a time; no queue sits in front of the bus
`timescale 1ns/1ps
`include "mbcc_defines.vh"
module mbcc_seq #(
  parameter ADDR_W = 15,
  parameter DATA_W = 16
) (
  input wire clk_sys,
  input wire reset,
  input wire req_valid,
  input wire req_write,
  input wire [ADDR_W-1:0] req_addr,
  input wire [DATA_W-1:0] req_wdata,
  output wire req_ready,
  output reg rd_valid,
  output reg [DATA_W-1:0] rd_data,
  output reg wr_done,
  output reg [ADDR_W-1:0] word_address_lines,
  output reg [DATA_W-1:0] data_bus_lines_out,
  output reg data_bus_lines_oe,
  input wire [DATA_W-1:0] data_bus_lines_in,
  output reg memory_strobe_n,
  output reg read_direction,
  output reg write_strobe_n,
  input wire ready,
  output reg wait_out,
  output reg [`MBCC_PH_W-1:0] phase_num
);
  reg [`MBCC_ST_W-1:0] state_r;
  reg [`MBCC_PH_W-1:0] phase_r;
  reg is_write_r;
  reg last_read_r;
  reg ready_s1_r;
  reg ready_s2_r;
  reg [DATA_W-1:0] din_s1_r;
  reg [DATA_W-1:0] din_s2_r;
  wire ph1;
  wire ph2;
  wire ph3;

  assign ph1 = (phase_r == `MBCC_PH1);
  assign ph2 = (phase_r == `MBCC_PH2);
  assign ph3 = (phase_r == `MBCC_PH3);
  // Taken at the phase four to phase one boundary of an idle cycle
  // Combinational so a waiting requester is taken on the very next boundary;
  // a write behind a read is held off until two full idle cycles have passed,
  // which keeps our drivers off the bus while the memory may still drive it
  assign req_ready = (state_r == `MBCC_ST_IDLE) && (phase_r == `MBCC_PH4) &&
    !(req_write && last_read_r);

  // Pin inputs pass two flops; the second stage alone feeds logic
  // The first stage may go metastable on a late pin change, so nothing but
  // the second stage reads it. The price is two phases of input latency,
  // which shows up as the set-up margin a slow memory must leave on ready.
  // Read data is staged the same way so it lines up with the ready path.
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      ready_s1_r <= 1'b0;
      ready_s2_r <= 1'b0;
      din_s1_r <= {DATA_W{1'b0}};
      din_s2_r <= {DATA_W{1'b0}};
    end
    else
    begin
      ready_s1_r <= ready;
      ready_s2_r <= ready_s1_r;
      din_s1_r <= data_bus_lines_in;
      din_s2_r <= din_s1_r;
    end
  end

  // Phase counter: four phases per clock cycle
  always @(posedge clk_sys)
  begin
    if (reset)
      phase_r <= `MBCC_PH1;
    else
      phase_r <= phase_r + 2'h1;
  end

  always @*
    phase_num = phase_r;

  // Cycle sequencer; ready sampled only at phase four of cycle one and wait
  // States step only on phase four to phase one boundaries, so every path
  // through the machine is a whole number of clock cycles long.
  // Bus outputs are registered and change only at a cycle start or end, or
  // for the write strobe three phases inside; the wait state touches none of
  // them, which is what lets a slow memory simply stretch its access.
  // Pulses rd_valid and wr_done default low and rise for one edge at the end.
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r <= `MBCC_ST_IDLE;
      is_write_r <= 1'b0;
      last_read_r <= 1'b0;
      word_address_lines <= {ADDR_W{1'b0}};
      data_bus_lines_out <= {DATA_W{1'b0}};
      data_bus_lines_oe <= 1'b0;
      memory_strobe_n <= 1'b1;
      read_direction <= 1'b0;
      write_strobe_n <= 1'b1;
      wait_out <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= {DATA_W{1'b0}};
      wr_done <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      wr_done <= 1'b0;
      case (state_r)
        `MBCC_ST_IDLE:
        begin
          if (req_valid && req_ready)
          begin
            // Bus outputs appear together at the cycle start
            state_r <= `MBCC_ST_CY1;
            is_write_r <= req_write;
            word_address_lines <= req_addr;
            memory_strobe_n <= 1'b0;
            read_direction <= !req_write;
            data_bus_lines_out <= req_wdata;
            data_bus_lines_oe <= req_write;
          end
          else if (phase_r == `MBCC_PH4)
            last_read_r <= 1'b0; // A full idle cycle clears the turnaround guard
        end
        `MBCC_ST_CY1:
        begin
          // Three phases after the cycle start the write strobe falls
          if (ph3 && is_write_r)
            write_strobe_n <= 1'b0;
          if (phase_r == `MBCC_PH4)
          begin
            // Ready seen at the next phase one boundary decides the path
            if (ready_s2_r)
              state_r <= `MBCC_ST_CY2;
            else
              state_r <= `MBCC_ST_WAIT;
          end
        end
        `MBCC_ST_WAIT:
        begin
          // All bus outputs held; only the wait flag moves
          // Re-raising the flag each wait cycle is harmless and keeps it
          // high across back to back wait states
          if (ph2)
            wait_out <= 1'b1;
          if (phase_r == `MBCC_PH4 && ready_s2_r)
            state_r <= `MBCC_ST_CY2;
        end
        `MBCC_ST_CY2:
        begin
          // Last clock cycle of the transfer; ready is no longer looked at
          if (ph1)
          begin
            // Write strobe rises three phases before the rest are released
            write_strobe_n <= 1'b1;
            if (!is_write_r)
              rd_data <= din_s2_r;
          end
          if (ph2)
            wait_out <= 1'b0;
          if (phase_r == `MBCC_PH4)
          begin
            // Cycle ends; at least two clock cycles long
            state_r <= `MBCC_ST_IDLE;
            memory_strobe_n <= 1'b1;
            read_direction <= 1'b0;
            data_bus_lines_oe <= 1'b0;
            last_read_r <= !is_write_r;
            rd_valid <= !is_write_r;
            wr_done <= is_write_r;
          end
        end
        // An illegal code falls back to idle with the bus left as it stands
        default:
          state_r <= `MBCC_ST_IDLE;
      endcase
    end
  end
endmodule // mbcc_seq

// file: core/mbcc_defines.vh
// Purpose: constants for the memory bus cycle sequencer
// Assumes: one system clock, four phase enables per processor clock cycle
// Notes: phase counter codes and state codes live here
`ifndef MBCC_DEFINES_VH
`define MBCC_DEFINES_VH
`define MBCC_PH_W 2
`define MBCC_PH1 2'h0
`define MBCC_PH2 2'h1
`define MBCC_PH3 2'h2
`define MBCC_PH4 2'h3
`define MBCC_ST_W 5
`define MBCC_ST_IDLE 5'h01
`define MBCC_ST_CY1 5'h02
`define MBCC_ST_WAIT 5'h04
`define MBCC_ST_CY2 5'h08
`define MBCC_ST_TURN 5'h10
`define MBCC_ADDR_MSB 14
`endif

// file: verif/mbcc_chk_assertions.sv
// Purpose: bus side timing checks
// Assumes: bound to mbcc_seq
// Notes: one clock domain
`timescale 1ns/1ps
module mbcc_chk (input wire clk_sys, input wire reset, input wire memory_strobe_n,
  input wire read_direction, input wire write_strobe_n, input wire data_bus_lines_oe,
  input wire wait_out, input wire [1:0] phase_num, input wire [14:0] word_address_lines);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Strobe release seen as its own step
  sequence s_we_end;
    !write_strobe_n ##1 write_strobe_n;
  endsequence
  chk_we_write: assert property (
    !write_strobe_n |-> !memory_strobe_n && !read_direction) else $error("we bad");
  chk_rd_quiet: assert property (
    read_direction |-> !data_bus_lines_oe && !memory_strobe_n) else $error("rd bad");
  chk_turn_quiet: assert property (
    $fell(read_direction) |-> !data_bus_lines_oe [*4]) else $error("turn bad");
  chk_cycle_len: assert property (
    $fell(memory_strobe_n) |-> !memory_strobe_n [*8]) else $error("len bad");
  chk_we_early: assert property (
    s_we_end |-> !memory_strobe_n) else $error("we late");
  chk_addr_hold: assert property (
    !write_strobe_n && $past(!write_strobe_n) |-> $stable(word_address_lines))
    else $error("addr moved");
  chk_wait_in: assert property (
    wait_out |-> !memory_strobe_n) else $error("wait bad");
  chk_wait_phase: assert property (
    $changed(wait_out) |-> phase_num == 2'h2) else $error("wait phase");
  chk_phase_step: assert property (
    1'b1 |=> phase_num == $past(phase_num) + 2'h1) else $error("phase bad");
endmodule // mbcc_chk
bind mbcc_seq mbcc_chk mbcc_chk_inst (.clk_sys, .reset, .memory_strobe_n, .read_direction,
  .write_strobe_n, .data_bus_lines_oe, .wait_out, .phase_num, .word_address_lines);

// file: verif/mbcc_mem.sv
// Purpose: static RAM, EPROM and decode glue
// Assumes: mode 0 ready high, 1 slow gate, 2 wait fed back, 3 delayed wait
// Notes: released bus shows the inverse of its last value
`timescale 1ns/1ps
module mbcc_mem (input wire clk_sys, input wire [1:0] mode, input wire [1:0] phase_num,
  input wire [14:0] word_address_lines, input wire [15:0] data_bus_lines_out,
  input wire memory_strobe_n, input wire read_direction, input wire write_strobe_n,
  input wire wait_out, output reg [15:0] data_bus_lines_in = 16'h0, output reg ready);
  reg [15:0] ram_r [0:7];
  reg we_q = 1'b1;
  reg wait_d = 1'b0;
  wire slow_region_select_n = ~word_address_lines[14]; // RAM half is slow
  // Ready glue; the delay flop steps once per clock cycle
  always @*
  begin
    case (mode)
      2'h0: ready = 1'b1;
      2'h1: ready = slow_region_select_n | wait_out;
      2'h2: ready = wait_out;
      default: ready = slow_region_select_n | wait_d;
    endcase
  end
  // Drive only on reads, so the bus never fights the writer
  always @(posedge clk_sys)
  begin
    we_q <= write_strobe_n;
    if (phase_num == 2'h1)
      wait_d <= wait_out;
    if (!memory_strobe_n && read_direction)
      data_bus_lines_in <= word_address_lines[14] ? ram_r[word_address_lines[2:0]] :
        {13'h0a50, word_address_lines[2:0]};
    else
      data_bus_lines_in <= ~data_bus_lines_in;
    if (write_strobe_n && !we_q && !memory_strobe_n && word_address_lines[14])
      ram_r[word_address_lines[2:0]] <= data_bus_lines_out;
  end
endmodule // mbcc_mem

// file: verif/testbench.sv
// Purpose: self-checking bench for the sequencer
// Assumes: memory model on the far side
// Notes: cycle length counted in edges from take to done
`timescale 1ns/1ps
module testbench;
  reg clk_sys = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  reg [14:0] req_addr = 15'h0;
  reg [15:0] req_wdata = 16'h0;
  reg [1:0] mode = 2'h0;
  wire req_ready, rd_valid, wr_done, data_bus_lines_oe, memory_strobe_n, read_direction;
  wire write_strobe_n, ready, wait_out;
  wire [15:0] rd_data, data_bus_lines_out, data_bus_lines_in;
  wire [14:0] word_address_lines;
  wire [1:0] phase_num;
  integer n_fail = 0, cmp_count = 0;
  always #50 clk_sys = ~clk_sys;
  mbcc_seq mbcc_seq_inst (.clk_sys, .reset, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_ready, .rd_valid, .rd_data, .wr_done, .word_address_lines, .data_bus_lines_out,
    .data_bus_lines_oe, .data_bus_lines_in, .memory_strobe_n, .read_direction,
    .write_strobe_n, .ready, .wait_out, .phase_num);
  mbcc_mem mbcc_mem_inst (.clk_sys, .mode, .phase_num, .word_address_lines,
    .data_bus_lines_out, .memory_strobe_n, .read_direction, .write_strobe_n, .wait_out,
    .data_bus_lines_in, .ready);
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task check(input string what, input [31:0] exp, input [31:0] got);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // One transfer; bounded waits for the take and for the done pulse
  task op(input w, input [14:0] a, input [15:0] d, input integer waits, input [15:0] exp);
    integer n;
  begin
    @(posedge clk_sys);
    #1 req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    n = 0;
    while (req_ready !== 1'b1 && n < 40)
    begin
      @(posedge clk_sys);
      #1 n = n + 1;
    end
    check("take wait", 1'b1, n < 40);
    // Ready seen settled; the request is taken at the next edge
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && wr_done !== 1'b1 && n < 40)
    begin
      @(posedge clk_sys);
      #1 n = n + 1;
    end
    check("cycle edges", 8 + 4 * waits, n);
    if (n >= 40)
      end_of_test;
    if (!w)
      check("read data", exp, rd_data);
  end
  endtask
  task t_basic;
  begin
    check("idle outputs", 5'h18, {memory_strobe_n, write_strobe_n, read_direction,
      data_bus_lines_oe, wait_out});
    op(1'b1, 15'h4003, 16'h1234, 0, 16'h0);
    op(1'b0, 15'h4003, 16'h0, 0, 16'h1234);
    op(1'b0, 15'h0002, 16'h0, 0, 16'h5282);
    req_write = 1'b1;
    req_valid = 1'b1;
    repeat (4)
    begin
      @(posedge clk_sys);
      #1 check("ready after read", 1'b0, req_ready);
    end
    req_valid = 1'b0;
    op(1'b1, 15'h4001, 16'hbeef, 0, 16'h0);
    $display("basic done");
  end
  endtask
  task t_waits;
  begin
    mode = 2'h1;
    op(1'b0, 15'h0002, 16'h0, 0, 16'h5282);
    op(1'b1, 15'h4006, 16'h0f0f, 2, 16'h0);
    mode = 2'h2;
    op(1'b0, 15'h4006, 16'h0, 2, 16'h0f0f);
    mode = 2'h3;
    op(1'b0, 15'h4001, 16'h0, 3, 16'hbeef);
    $display("waits done");
  end
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 reset = 1'b0;
    t_basic;
    t_waits;
    end_of_test;
  end
endmodule // testbench
